// [rtl/ncm_params.svh]
`ifndef NCM_PARAMS_SVH
`define NCM_PARAMS_SVH
`define NCM_PH_W      32
`define NCM_HALF_W    16
`define NCM_LUT_W     20
`define NCM_DIN_W     16
`define NCM_SHIFT_W   19
`define NCM_PROD_W    33
`define NCM_ACC_W     35
`define NCM_AUX_W     20
`define NCM_OUT_W     20
`define NCM_CW_W      18
`define NCM_ITER      16
`define NCM_CORDIC_K  18'h04DBA
`define NCM_POS_FULL  16'h7FFF
`define NCM_NEG_FULL  16'h8001
`define NCM_SEL_FLO   2'h0
`define NCM_SEL_FHI   2'h1
`define NCM_SEL_PH    2'h2
`define NCM_QPH_LOW_W 14
`define NCM_MSB_OUT   19
`define NCM_GROW_AUX  15
`define NCM_GROW_MAC  30
`endif

// [rtl/ncm_pkg.sv]
package ncm_pkg;
   typedef struct packed {
      logic       offset_freq_gate_n;
      logic [1:0] quad_phase_sel;
      logic       phase_load_n;
      logic       phase_range_sel;
      logic       time_incr_load_n;
      logic       bypass_timer_clear_n;
      logic       input_latch_en_n;
      logic [1:0] input_shift_sel;
      logic       accumulate_en;
      logic [1:0] output_select;
      logic       output_format_sel;
      logic       peak_hold_n;
      logic       phase_source_sel;
      logic       center_freq_load_n;
      logic       offset_freq_load_n;
      logic       phase_reg_load_n;
   } ncm_ctrl_s;
   typedef struct packed {
      logic [15:0] control_word_bus;
      logic [1:0]  input_reg_sel;
      logic        cs_n;
      logic        wr_n;
   } ncm_host_s;
   typedef struct packed {
      logic [15:0] real_in;
      logic [15:0] imag_in;
   } ncm_vec_s;
endpackage

// [rtl/ncm_top.sv]
`timescale 1ns/10ps
`include "ncm_params.svh"
module ncm_top (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire ncm_pkg::ncm_ctrl_s ctrl_in,
   input  wire ncm_pkg::ncm_host_s host_in,
   input  wire ncm_pkg::ncm_vec_s  vec_in,
   output logic [19:0]            real_out,
   output logic [19:0]            imag_out,
   output logic [1:0]             growth_level,
   output logic                   phase_carry_out_n,
   output logic                   timer_carry_out_n
);
   localparam logic [`NCM_LUT_W:0] ATAN [0:`NCM_ITER-1] = '{
      21'h020000, 21'h012E40, 21'h009FB4, 21'h005111, 21'h0028B1, 21'h00145E,
      21'h000A2F, 21'h000518, 21'h00028C, 21'h000146, 21'h0000A3, 21'h000051,
      21'h000029, 21'h000014, 21'h00000A, 21'h000005};

   // Every pin passes two flops; the second stage serves as the registered enable.
   ncm_pkg::ncm_ctrl_s ctrl_m_reg, ctrl_reg;
   ncm_pkg::ncm_host_s host_m_reg, host_reg;
   ncm_pkg::ncm_vec_s  vec_m_reg, vec_reg;
   logic               wr_d_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_m_reg <= '1;
         ctrl_reg   <= '1;
         host_m_reg <= '1;
         host_reg   <= '1;
         vec_m_reg  <= '0;
         vec_reg    <= '0;
         wr_d_reg   <= 1'b1;
      end else begin
         ctrl_m_reg <= ctrl_in;
         ctrl_reg   <= ctrl_m_reg;
         host_m_reg <= host_in;
         host_reg   <= host_m_reg;
         vec_m_reg  <= vec_in;
         vec_reg    <= vec_m_reg;
         wr_d_reg   <= host_reg.wr_n;
      end
   end

   // Host input registers.
   logic [15:0] in_lo_reg, in_hi_reg, in_ph_reg;
   logic        wr_rise;
   assign wr_rise = host_reg.wr_n & ~wr_d_reg & ~host_reg.cs_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_lo_reg <= '0;
         in_hi_reg <= '0;
         in_ph_reg <= '0;
      end else if (wr_rise) begin
         unique case (host_reg.input_reg_sel)
            `NCM_SEL_FLO: in_lo_reg <= host_reg.control_word_bus;
            `NCM_SEL_FHI: in_hi_reg <= host_reg.control_word_bus;
            `NCM_SEL_PH:  in_ph_reg <= host_reg.control_word_bus;
            default: ;
         endcase
      end
   end

   // Frequency, phase and time increment registers.
   logic [31:0] center_reg, offset_reg, tincr_reg;
   logic [15:0] phase_reg;
   logic [1:0]  qbits;

   always_comb begin
      unique case (ctrl_reg.quad_phase_sel)
         2'h0: qbits = 2'h0;
         2'h1: qbits = 2'h1;
         2'h2: qbits = 2'h3;
         2'h3: qbits = 2'h2;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         center_reg <= '0;
         offset_reg <= '0;
         tincr_reg  <= '0;
         phase_reg  <= '0;
      end else begin
         if (!ctrl_reg.center_freq_load_n)
            center_reg <= {in_hi_reg, in_lo_reg};
         if (!ctrl_reg.offset_freq_load_n)
            offset_reg <= {in_hi_reg, in_lo_reg};
         if (!ctrl_reg.time_incr_load_n)
            tincr_reg <= {in_hi_reg, in_lo_reg};
         if (!ctrl_reg.phase_reg_load_n) begin
            if (ctrl_reg.phase_source_sel)
               phase_reg <= in_ph_reg;
            else
               phase_reg <= {qbits, `NCM_QPH_LOW_W'(0)};
         end
      end
   end

   // Phase accumulator and phase adder.
   logic [31:0] pacc_reg, arg_reg, incr;
   logic [32:0] pacc_next;
   logic [15:0] arg_hi;

   assign incr      = center_reg + (ctrl_reg.offset_freq_gate_n ? offset_reg : '0);
   assign pacc_next = {1'b0, (ctrl_reg.phase_load_n ? pacc_reg : '0)} + {1'b0, incr};
   assign arg_hi    = pacc_reg[31:16] + phase_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pacc_reg          <= '0;
         arg_reg           <= '0;
         phase_carry_out_n <= 1'b1;
      end else begin
         pacc_reg          <= pacc_next[31:0];
         phase_carry_out_n <= ~pacc_next[32];
         // Clearing the top bit folds the circle onto its first half.
         arg_reg <= {arg_hi[15] & ctrl_reg.phase_range_sel, arg_hi[14:0], pacc_reg[15:0]};
      end
   end

   // Time accumulator; with feedback cleared the sum can never carry.
   logic [31:0] tacc_reg;
   logic [32:0] tacc_next;
   assign tacc_next = {1'b0, (ctrl_reg.bypass_timer_clear_n ? tacc_reg : '0)} + {1'b0, tincr_reg};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tacc_reg          <= '0;
         timer_carry_out_n <= 1'b1;
      end else begin
         tacc_reg          <= tacc_next[31:0];
         timer_carry_out_n <= ~tacc_next[32];
      end
   end

   // Sine and cosine by rotation; costs adders instead of a large table.
   function automatic logic [15:0] sat16(input logic signed [`NCM_CW_W-1:0] v);
      if (v > $signed({2'b00, `NCM_POS_FULL}))
         return `NCM_POS_FULL;
      else if (v < $signed({2'b11, `NCM_NEG_FULL}))
         return `NCM_NEG_FULL;
      else
         return v[15:0];
   endfunction

   function automatic logic [31:0] sincos(input logic [`NCM_LUT_W-1:0] a);
      logic signed [`NCM_CW_W-1:0] x, y, xt;
      logic signed [`NCM_LUT_W:0]  z;
      logic signed [`NCM_CW_W-1:0] c, s;
      x = `NCM_CORDIC_K;
      y = '0;
      z = $signed({3'b000, a[17:0]});
      xt = '0;
      for (int i = 0; i < `NCM_ITER; i++) begin
         xt = x;
         if (!z[`NCM_LUT_W]) begin
            x = x - (y >>> i);
            y = y + (xt >>> i);
            z = z - $signed(ATAN[i]);
         end else begin
            x = x + (y >>> i);
            y = y - (xt >>> i);
            z = z + $signed(ATAN[i]);
         end
      end
      unique case (a[19:18])
         2'h0: begin c = x;  s = y;  end
         2'h1: begin c = -y; s = x;  end
         2'h2: begin c = -x; s = -y; end
         2'h3: begin c = y;  s = -x; end
      endcase
      return {sat16(s), sat16(c)};
   endfunction

   logic [15:0] sin_reg, cos_reg;
   logic [31:0] sc;
   assign sc = sincos(arg_reg[31:32-`NCM_LUT_W]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sin_reg <= '0;
         cos_reg <= '0;
      end else if (!ctrl_reg.bypass_timer_clear_n) begin
         sin_reg <= arg_reg[31:16];
         cos_reg <= arg_reg[15:0];
      end else begin
         sin_reg <= sc[31:16];
         cos_reg <= sc[15:0];
      end
   end

   // Input registers and shifters.
   logic signed [`NCM_SHIFT_W-1:0] rin_reg, iin_reg;
   logic signed [15:0]             rsh, ish;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rin_reg <= '0;
         iin_reg <= '0;
      end else if (!ctrl_reg.input_latch_en_n) begin
         rin_reg <= `NCM_SHIFT_W'($signed(vec_reg.real_in));
         iin_reg <= `NCM_SHIFT_W'($signed(vec_reg.imag_in));
      end
   end

   assign rsh = 16'(rin_reg >>> ctrl_reg.input_shift_sel);
   assign ish = 16'(iin_reg >>> ctrl_reg.input_shift_sel);

   // Complex multiplier, accumulators and growth detect.
   logic signed [`NCM_PROD_W-1:0] pr_reg, pi_reg, pr, pi;
   logic signed [`NCM_ACC_W-1:0]  ar_reg, ai_reg;
   logic signed [`NCM_AUX_W-1:0]  xr_reg, xi_reg;

   // Operands are widened before the multiply so no tool can keep only a sixteen-bit product.
   assign pr = `NCM_PROD_W'($signed(cos_reg)) * `NCM_PROD_W'(rsh)
             - `NCM_PROD_W'($signed(sin_reg)) * `NCM_PROD_W'(ish);
   assign pi = `NCM_PROD_W'($signed(cos_reg)) * `NCM_PROD_W'(ish)
             + `NCM_PROD_W'($signed(sin_reg)) * `NCM_PROD_W'(rsh);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pr_reg <= '0;
         pi_reg <= '0;
         ar_reg <= '0;
         ai_reg <= '0;
         xr_reg <= '0;
         xi_reg <= '0;
      end else begin
         pr_reg <= pr;
         pi_reg <= pi;
         ar_reg <= (ctrl_reg.accumulate_en ? ar_reg : '0) + `NCM_ACC_W'(pr_reg);
         ai_reg <= (ctrl_reg.accumulate_en ? ai_reg : '0) + `NCM_ACC_W'(pi_reg);
         xr_reg <= (ctrl_reg.accumulate_en ? xr_reg : '0) + `NCM_AUX_W'(rsh);
         xi_reg <= (ctrl_reg.accumulate_en ? xi_reg : '0) + `NCM_AUX_W'(ish);
      end
   end

   function automatic logic [1:0] grow(input logic [3:0] b);
      if (b[3] != b[2])
         return 2'h3;
      else if (b[2] != b[1])
         return 2'h2;
      else if (b[1] != b[0])
         return 2'h1;
      else
         return 2'h0;
   endfunction

   logic [1:0] g0, g1, gmax;
   always_comb begin
      g0   = grow(ar_reg[`NCM_GROW_MAC+:4]);
      g1   = grow(ai_reg[`NCM_GROW_MAC+:4]);
      gmax = (g0 > g1) ? g0 : g1;
      g0   = grow(xr_reg[`NCM_GROW_AUX+:4]);
      g1   = grow(xi_reg[`NCM_GROW_AUX+:4]);
      if (g0 > gmax)
         gmax = g0;
      if (g1 > gmax)
         gmax = g1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         growth_level <= '0;
      else if (!ctrl_reg.peak_hold_n && growth_level > gmax)
         growth_level <= growth_level;
      else
         growth_level <= gmax;
   end

   // Output multiplexer and format.
   function automatic logic [19:0] omux(input logic [1:0] sel, input logic [`NCM_ACC_W-1:0] a,
                                        input logic [`NCM_AUX_W-1:0] x, input logic fmt);
      logic [19:0] o;
      unique case (sel)
         2'h0: o = a[34:15];
         2'h1: o = {a[34:31], 1'b0, a[14:0]};
         2'h2: o = x;
         2'h3: o = '0;
      endcase
      o[`NCM_MSB_OUT] = o[`NCM_MSB_OUT] ^ ~fmt;
      return o;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         real_out <= '0;
         imag_out <= '0;
      end else begin
         real_out <= omux(ctrl_reg.output_select, ar_reg, xr_reg, ctrl_reg.output_format_sel);
         imag_out <= omux(ctrl_reg.output_select, ai_reg, xi_reg, ctrl_reg.output_format_sel);
      end
   end
endmodule

// [sim/ncm_host_model.sv]
`timescale 1ns/10ps
module ncm_host_model (
   input  wire logic          clk,
   output ncm_pkg::ncm_host_s host
);
   initial host = '{control_word_bus: 16'h0000, input_reg_sel: 2'h3, cs_n: 1'b1, wr_n: 1'b1};
   // Strobe phases last four cycles so the two-flop synchroniser cannot miss an edge.
   task automatic write_word(input logic [1:0] sel, input logic [15:0] data);
      host.control_word_bus = data;
      host.input_reg_sel = sel;
      host.cs_n = 1'b0;
      host.wr_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 host.wr_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 host.cs_n = 1'b1;
      host.control_word_bus = ~data;
      // Idle gap so a following write never reasserts select in the same time step.
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule

// [sim/ncm_top_properties.sv]
`timescale 1ns/10ps
module ncm_top_properties (
   input wire logic               clk,
   input wire logic               rst_n,
   input wire ncm_pkg::ncm_ctrl_s ctrl_in,
   input wire ncm_pkg::ncm_vec_s  vec_in,
   input wire logic [19:0]        real_out,
   input wire logic [19:0]        imag_out,
   input wire logic [1:0]         growth_level,
   input wire logic               phase_carry_out_n,
   input wire logic               timer_carry_out_n
);
   logic zv;
   assign zv = vec_in == 32'h0 && !ctrl_in.input_latch_en_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_timer_clr_quiet: assert property (!ctrl_in.bypass_timer_clear_n [*6] |-> timer_carry_out_n)
      else $error("timer carry while cleared");
   a_phase_load_quiet: assert property (!ctrl_in.phase_load_n [*6] |-> phase_carry_out_n)
      else $error("phase carry while loading");
   a_peak_hold_mono: assert property (!ctrl_in.peak_hold_n [*6] |-> growth_level >= $past(growth_level))
      else $error("held growth fell");
   a_zero_vec_out: assert property ((zv && !ctrl_in.accumulate_en && ctrl_in.output_format_sel) [*8]
      |-> real_out == 20'h00000 && imag_out == 20'h00000)
      else $error("zero vector gave nonzero output");
   a_zero_vec_growth: assert property ((zv && !ctrl_in.accumulate_en && ctrl_in.peak_hold_n) [*8]
      |-> growth_level == 2'h0)
      else $error("growth on zero data");
   a_reserved_fmt: assert property ((ctrl_in.output_select == 2'h3 && !ctrl_in.output_format_sel) [*6]
      |-> real_out == 20'h80000 && imag_out == 20'h80000)
      else $error("reserved select output wrong");
   a_acc_zero_hold: assert property ((zv && ctrl_in.accumulate_en && ctrl_in.output_select == 2'h0
      && ctrl_in.output_format_sel) [*8] |=> $stable(real_out) && $stable(imag_out))
      else $error("accumulator moved on zero input");
   a_carry_in_reset: assert property ($rose(rst_n) |-> phase_carry_out_n && timer_carry_out_n)
      else $error("carry low at reset release");
endmodule
bind ncm_top ncm_top_properties chk_u (.clk(clk), .rst_n(rst_n), .ctrl_in(ctrl_in), .vec_in(vec_in),
   .real_out(real_out), .imag_out(imag_out), .growth_level(growth_level),
   .phase_carry_out_n(phase_carry_out_n), .timer_carry_out_n(timer_carry_out_n));

// [sim/nco_complex_mixer_tb.sv]
`timescale 1ns/10ps
module nco_complex_mixer_tb;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   ncm_pkg::ncm_ctrl_s ctrl;
   ncm_pkg::ncm_vec_s  vec;
   ncm_pkg::ncm_host_s host;
   logic [19:0]        real_out, imag_out, a;
   logic [1:0]         growth_level;
   logic               phase_carry_out_n, timer_carry_out_n;
   int                 failures = 0;
   int                 checks_done = 0;
   logic [15:0]        qoff [4] = '{16'h0000, 16'h4000, 16'hC000, 16'h8000};
   always #4 clk = ~clk;
   ncm_host_model host_u (.clk(clk), .host(host));
   ncm_top dut_u (.clk(clk), .rst_n(rst_n), .ctrl_in(ctrl), .host_in(host), .vec_in(vec), .real_out(real_out),
      .imag_out(imag_out), .growth_level(growth_level), .phase_carry_out_n(phase_carry_out_n),
      .timer_carry_out_n(timer_carry_out_n));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Sine and cosine come from an approximation, so their values, zeros as well as full scale, are compared with a margin.
   task automatic near(input logic [19:0] got, input logic [19:0] exp);
      logic [19:0] d;
      d = got - exp;
      checks_done++;
      if ($isunknown(got) || (d > 20'h00010 && d < 20'hFFFF0)) begin
         failures++;
         $display("MISMATCH t=%0t got %h expected about %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Cosine or sine times 7FFF, seen through the output multiplexer with two's complement format.
   function automatic logic [19:0] mix(input logic [15:0] c, input logic [1:0] os);
      logic signed [34:0] p;
      p = $signed(c) * $signed(16'h7FFF);
      return (os == 2'h0) ? p[34:15] : {p[34:31], 1'b0, p[14:0]};
   endfunction
   task automatic load32(input logic [31:0] w);
      host_u.write_word(2'h0, w[15:0]);
      host_u.write_word(2'h1, w[31:16]);
   endtask
   task automatic t_bypass_mix;
      load32(32'h5678_1234);
      ctrl.center_freq_load_n = 1'b0;
      step(6);
      ctrl.center_freq_load_n = 1'b1;
      for (int q = 0; q < 4; q++) begin
         ctrl.quad_phase_sel = 2'(q);
         step(14);
         chk(real_out, mix(16'h1234, 2'h0));
         chk(imag_out, mix(16'h5678 + qoff[q], 2'h0));
      end
      ctrl.phase_range_sel = 1'b0;
      step(14);
      chk(imag_out, mix(16'h5678, 2'h0));
      ctrl.output_select = 2'h1;
      step(10);
      chk(real_out, mix(16'h1234, 2'h1));
      ctrl.output_format_sel = 1'b0;
      step(10);
      chk(real_out, mix(16'h1234, 2'h1) ^ 20'h80000);
      ctrl.output_format_sel = 1'b1;
      ctrl.output_select = 2'h0;
      vec = '{real_in: 16'h0000, imag_in: 16'h7FFF};
      step(14);
      chk(real_out, mix(16'hA988, 2'h0));
      chk(imag_out, mix(16'h1234, 2'h0));
      vec = '{real_in: 16'h7FFF, imag_in: 16'h0000};
   endtask
   task automatic t_sincos;
      logic [15:0] ec [4] = '{16'h0000, 16'h8001, 16'h7FFF, 16'h0000};
      logic [15:0] es [4] = '{16'h7FFF, 16'h0000, 16'h0000, 16'h8001};
      ctrl.bypass_timer_clear_n = 1'b1;
      ctrl.phase_range_sel = 1'b1;
      ctrl.accumulate_en = 1'b0;
      ctrl.input_shift_sel = 2'h0;
      vec = '{real_in: 16'h7FFF, imag_in: 16'h0000};
      // The phase rests at a quarter circle, so every quadrature step lands on an axis.
      for (int q = 0; q < 4; q++) begin
         ctrl.quad_phase_sel = 2'(q);
         step(14);
         near(real_out, mix(ec[q], 2'h0));
         near(imag_out, mix(es[q], 2'h0));
      end
      ctrl.input_latch_en_n = 1'b1;
      vec = '0;
      step(10);
      near(imag_out, mix(es[3], 2'h0));
      ctrl.input_latch_en_n = 1'b0;
   endtask
   task automatic t_shift_acc;
      ctrl.output_select = 2'h2;
      for (int s = 0; s < 4; s++) begin
         ctrl.input_shift_sel = 2'(s);
         step(10);
         chk(real_out, 20'h07FFF >> s);
         chk(imag_out, 20'h00000);
      end
      ctrl.accumulate_en = 1'b1;
      ctrl.peak_hold_n = 1'b0;
      step(8);
      a = real_out;
      step(1);
      chk(real_out - a, 20'h00FFF);
      step(40);
      chk({18'h0, growth_level}, 20'h00003);
      ctrl.peak_hold_n = 1'b1;
      ctrl.accumulate_en = 1'b0;
      vec = '0;
      step(14);
      chk({real_out[17:0], growth_level}, 20'h00000);
      ctrl.output_select = 2'h3;
      ctrl.output_format_sel = 1'b0;
      step(10);
      chk(imag_out, 20'h80000);
      ctrl.output_select = 2'h0;
      ctrl.output_format_sel = 1'b1;
      ctrl.accumulate_en = 1'b1;
      step(14);
      chk(real_out, 20'h00000);
   endtask
   task automatic count(input int ep, input int et);
      int p = 0;
      int t = 0;
      for (int i = 0; i < 40; i++) begin
         step(1);
         p += (phase_carry_out_n === 1'b0);
         t += (timer_carry_out_n === 1'b0);
      end
      chk(20'(p), 20'(ep));
      chk(20'(t), 20'(et));
   endtask
   task automatic t_carries;
      load32(32'h4000_0000);
      {ctrl.center_freq_load_n, ctrl.time_incr_load_n, ctrl.offset_freq_load_n} = 3'h0;
      step(6);
      {ctrl.center_freq_load_n, ctrl.time_incr_load_n, ctrl.offset_freq_load_n} = 3'h7;
      ctrl.bypass_timer_clear_n = 1'b1;
      ctrl.phase_load_n = 1'b1;
      step(8);
      count(10, 10);
      ctrl.offset_freq_gate_n = 1'b1;
      step(6);
      count(20, 10);
      ctrl.offset_freq_gate_n = 1'b0;
      step(6);
      count(10, 10);
      ctrl.bypass_timer_clear_n = 1'b0;
      ctrl.phase_load_n = 1'b0;
      step(6);
      count(0, 0);
   endtask
   initial begin
      ctrl = '{offset_freq_gate_n: 0, quad_phase_sel: 0, phase_load_n: 0, phase_range_sel: 1, time_incr_load_n: 1,
         bypass_timer_clear_n: 0, input_latch_en_n: 0, input_shift_sel: 0, accumulate_en: 0, output_select: 0,
         output_format_sel: 1, peak_hold_n: 1, phase_source_sel: 0, center_freq_load_n: 1,
         offset_freq_load_n: 1, phase_reg_load_n: 0};
      vec = '{real_in: 16'h7FFF, imag_in: 16'h0000};
      step(12);
      chk({16'h0, growth_level, phase_carry_out_n, timer_carry_out_n}, 20'h00003);
      chk(real_out | imag_out, 20'h00000);
      rst_n = 1'b1;
      step(2);
      t_bypass_mix();
      t_shift_acc();
      t_carries();
      t_sincos();
      stop_test();
   end
endmodule
